// ### hw/logic_cell_defs.vh
// Functional notes
// RULE1: enable clear forces every cell output low; code clears cell_out and pin_out only, pin_oe_n still follows pin enable
// RULE2: rise enable pulses interrupt on output rising
// RULE3: fall enable pulses interrupt on output falling
// RULE4: pin driven only while pin enable set
// RULE5: status bit reads current cell output level
// RULE6: output invert bit flips final cell output
// RULE7: modes 000/001/010 are AND-OR, OR-XOR, AND4
// RULE8: 011 SR latch, 100 D flop with S/R
// RULE9: 101 two-input D flop with reset
// RULE10: 110 JK flop with reset
// RULE11: 111 transparent latch with set and reset
// RULE12: per-gate invert bits, bit3..0 gates 4..1
// RULE13: source 4 selection table
// RULE14: source 3 selection table
// RULE15: source 2 selection table
// RULE16: source 1 selection table
// RULE17: true enable admits plain source into gate
// RULE18: negated enable admits inverted source into gate
// RULE19: low gate register holds gates 1 and 2
// RULE20: high gate register holds gates 3 and 4
// RULE21: gate is OR of enabled terms, else zero
// RULE22: sequential modes use fixed gate role mapping
`ifndef LOGIC_CELL_DEFS_VH
`define LOGIC_CELL_DEFS_VH

// register indices; byte address is four times the index
`define IDX_W          11
`define IDX_CON_LOW    11'h470
`define IDX_CON_HIGH   11'h472
`define IDX_IN_SEL     11'h474
`define IDX_GATE_LOW   11'h478
`define IDX_GATE_HIGH  11'h47A

// bus geometry
`define ADR_W          13
`define DAT_W          32
`define REG_W          16
`define ZERO_REG       16'h0000
`define ZERO_PAD       16'h0000

// control low fields
`define BIT_ENABLE     15
`define BIT_RISE_IRQ   11
`define BIT_FALL_IRQ   10
`define BIT_PIN_OE     7
`define BIT_STATUS     6
`define BIT_OUT_INV    5
`define MODE_HI        2
`define MODE_LO        0

// control high field
`define GINV_HI        3
`define GINV_LO        0

// input select fields
`define S4_HI          14
`define S4_LO          12
`define S3_HI          10
`define S3_LO          8
`define S2_HI          6
`define S2_LO          4
`define S1_HI          2
`define S1_LO          0

// mode codes
`define MODE_AND_OR    3'h0
`define MODE_OR_XOR    3'h1
`define MODE_AND4      3'h2
`define MODE_SR_LATCH  3'h3
`define MODE_DFF_SR    3'h4
`define MODE_DFF2_R    3'h5
`define MODE_JK_R      3'h6
`define MODE_LATCH_SR  3'h7

`endif

// ### hw/logic_cell_gates.v
`timescale 1ns/100ps
`default_nettype none
// four gates fed by true and negated source terms
module logic_cell_gates #(
    parameter NGATE = 4,
    parameter NSRC  = 4
) (
    // selected data sources
    input  wire [NSRC-1:0]        src,
    // enable bits, one byte per gate
    input  wire [2*NSRC*NGATE-1:0] en,
    // per-gate inversion
    input  wire [NGATE-1:0]       inv,
    // gate results after inversion
    output wire [NGATE-1:0]       gate
);

    genvar gi;
    genvar si;
    generate
        for (gi = 0; gi < NGATE; gi = gi + 1) begin : g_gate
            wire [NSRC-1:0] term_t;   // plain terms
            wire [NSRC-1:0] term_n;   // inverted terms
            for (si = 0; si < NSRC; si = si + 1) begin : g_src
                // odd bit admits plain source [RULE17]
                assign term_t[si] = en[gi*2*NSRC + 2*si + 1] & src[si];
                // even bit admits inverted source [RULE18]
                assign term_n[si] = en[gi*2*NSRC + 2*si] & ~src[si];
            end
            // or of enabled terms, zero when none set [RULE21]
            // then per-gate inversion [RULE12]
            assign gate[gi] = (|term_t | |term_n) ^ inv[gi];
        end
    endgenerate

endmodule // logic_cell_gates
`default_nettype wire

// ### hw/logic_cell.v
// The Wishbone interface to the registers was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "logic_cell_defs.vh"
// configurable logic cell, second instance, wishbone slave
module logic_cell (
    // clock and reset
    input  wire                core_clk,
    input  wire                nrst,
    // wishbone classic slave
    input  wire                wb_cyc_i,
    input  wire                wb_stb_i,
    input  wire                wb_we_i,
    input  wire [`ADR_W-1:0]   wb_adr_i,
    input  wire [3:0]          wb_sel_i,
    input  wire [`DAT_W-1:0]   wb_dat_i,
    output reg  [`DAT_W-1:0]   wb_dat_o,
    output reg                 wb_ack_o,
    // source 1 candidates
    input  wire                cell_input_pin_a,
    input  wire                peripheral_clock,
    input  wire                secondary_oscillator,
    input  wire                low_power_rc_clock,
    input  wire                reference_clock_out,
    input  wire                timer2_match,
    input  wire                timer3_match,
    // source 2 candidates
    input  wire                cell_input_pin_b,
    input  wire                cell1_output,
    input  wire                comparator1_output,
    input  wire                uart2_transmit,
    input  wire                adc_done,
    input  wire                dma0_irq,
    // source 3 candidates
    input  wire                cell_input_pin_c,
    input  wire                comparator2_output,
    input  wire                serial2_data_out,
    input  wire                uart2_receive,
    input  wire                dma1_irq,
    // source 4 candidates
    input  wire                cell_input_pin_d,
    input  wire                comparator3_output,
    input  wire                serial2_data_in,
    // compare module outputs
    input  wire                compare1_output,
    input  wire                compare2_output,
    input  wire                compare3_output,
    // cell result and pin
    output reg                 cell_out,
    output reg                 pin_out,
    output reg                 pin_oe_n,
    // cell interrupt pulse
    output reg                 cell_irq
);

    // software registers
    reg                enable_q;       // cell enable
    reg                rise_irq_q;     // rising edge interrupt enable
    reg                fall_irq_q;     // falling edge interrupt enable
    reg                pin_oe_q;       // pin output enable
    reg                out_inv_q;      // final output inversion
    reg  [2:0]         mode_q;         // logic function
    reg  [3:0]         gate_inv_q;     // per-gate inversion
    reg  [`REG_W-1:0]  in_sel_q;       // source selects
    reg  [`REG_W-1:0]  gate_lo_q;      // gates 1 and 2 enables
    reg  [`REG_W-1:0]  gate_hi_q;      // gates 3 and 4 enables

    // cell state
    reg                state_q;        // flop or latch storage
    reg                state_d;
    reg                gclk_q;         // gate 1 last value
    reg                cell_out_d;

    // bus decode
    wire [`IDX_W-1:0]  idx;
    wire               req;
    wire               wr;
    wire               hit_cl;
    wire               hit_ch;
    wire               hit_sel;
    wire               hit_gl;
    wire               hit_gh;
    reg  [`REG_W-1:0]  rd_word;

    // source mux
    wire [7:0]         cand1;
    wire [7:0]         cand2;
    wire [7:0]         cand3;
    wire [7:0]         cand4;
    wire [3:0]         src;
    wire [3:0]         gate;

    // gate roles for sequential modes
    wire               g_clk;
    wire               g_d;
    wire               g_r;
    wire               g_s;
    wire               clk_rise;
    reg                comb_val;
    reg                raw;

    // address index and request qualification
    assign idx     = wb_adr_i[`ADR_W-1:2];
    assign req     = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wr      = req & wb_we_i;
    assign hit_cl  = (idx == `IDX_CON_LOW);
    assign hit_ch  = (idx == `IDX_CON_HIGH);
    assign hit_sel = (idx == `IDX_IN_SEL);
    assign hit_gl  = (idx == `IDX_GATE_LOW);
    assign hit_gh  = (idx == `IDX_GATE_HIGH);

    // candidate vectors, index is the select code
    // unimplemented codes read as zero
    assign cand1 = {timer3_match, timer2_match, 1'b0, reference_clock_out,
                    low_power_rc_clock, secondary_oscillator,
                    peripheral_clock, cell_input_pin_a};          // [RULE16]
    assign cand2 = {compare2_output, compare1_output, dma0_irq, adc_done,
                    uart2_transmit, comparator1_output,
                    cell1_output, cell_input_pin_b};              // [RULE15]
    // code 001 of source 3 is this cell's own output
    assign cand3 = {compare3_output, compare2_output, dma1_irq,
                    uart2_receive, serial2_data_out,
                    comparator2_output, cell_out,
                    cell_input_pin_c};                            // [RULE14]
    assign cand4 = {compare3_output, compare1_output, 1'b0, 1'b0,
                    serial2_data_in, comparator3_output,
                    cell1_output, cell_input_pin_d};              // [RULE13]

    // mux out the four sources
    assign src[0] = cand1[in_sel_q[`S1_HI:`S1_LO]];
    assign src[1] = cand2[in_sel_q[`S2_HI:`S2_LO]];
    assign src[2] = cand3[in_sel_q[`S3_HI:`S3_LO]];
    assign src[3] = cand4[in_sel_q[`S4_HI:`S4_LO]];

    // gate network; low register feeds gates 1,2, high feeds 3,4
    logic_cell_gates #(
        .NGATE (4),
        .NSRC  (4)
    ) u_gates (
        .src   (src),
        .en    ({gate_hi_q, gate_lo_q}),                         // [RULE19] [RULE20]
        .inv   (gate_inv_q),
        .gate  (gate)
    );

    // fixed roles: gate1 clock/enable, gate2 data, gate3 reset, gate4 set
    assign g_clk    = gate[0];                                    // [RULE22]
    assign g_d      = gate[1];
    assign g_r      = gate[2];
    assign g_s      = gate[3];
    // clock edge seen through the sampled gate, inputs are synchronous
    assign clk_rise = g_clk & ~gclk_q;

    // combinational functions
    always @* begin
        case (mode_q)
            `MODE_AND_OR: begin
                comb_val = (gate[0] & gate[1]) | (gate[2] & gate[3]); // [RULE7]
            end
            `MODE_OR_XOR: begin
                comb_val = (gate[0] | gate[1]) ^ (gate[2] | gate[3]); // [RULE7]
            end
            `MODE_AND4: begin
                comb_val = &gate;                                 // [RULE7]
            end
            default: begin
                comb_val = 1'b0;
            end
        endcase
    end

    // sequential functions; reset always wins over set
    always @* begin
        state_d = state_q;
        case (mode_q)
            `MODE_SR_LATCH: begin
                // set from gates 1|2, reset from gates 3|4
                if (gate[2] | gate[3]) begin
                    state_d = 1'b0;                               // [RULE8]
                end else if (gate[0] | gate[1]) begin
                    state_d = 1'b1;
                end
            end
            `MODE_DFF_SR: begin
                if (g_r) begin
                    state_d = 1'b0;                               // [RULE8]
                end else if (g_s) begin
                    state_d = 1'b1;
                end else if (clk_rise) begin
                    state_d = g_d;
                end
            end
            `MODE_DFF2_R: begin
                // two data gates anded, gate 4 is second data
                if (g_r) begin
                    state_d = 1'b0;                               // [RULE9]
                end else if (clk_rise) begin
                    state_d = g_d & g_s;
                end
            end
            `MODE_JK_R: begin
                // gate 2 is j, gate 4 is k
                if (g_r) begin
                    state_d = 1'b0;                               // [RULE10]
                end else if (clk_rise) begin
                    case ({g_d, g_s})
                        2'h2: state_d = 1'b1;
                        2'h1: state_d = 1'b0;
                        2'h3: state_d = ~state_q;
                        default: state_d = state_q;
                    endcase
                end
            end
            `MODE_LATCH_SR: begin
                // transparent while gate 1 is high
                if (g_r) begin
                    state_d = 1'b0;                               // [RULE11]
                end else if (g_s) begin
                    state_d = 1'b1;
                end else if (g_clk) begin
                    state_d = g_d;
                end
            end
            default: begin
                state_d = 1'b0;
            end
        endcase
        // disabled cell holds no state
        if (!enable_q) begin
            state_d = 1'b0;
        end
    end

    // final output: function result, inverted, gated by enable
    always @* begin
        if (mode_q == `MODE_AND_OR || mode_q == `MODE_OR_XOR ||
            mode_q == `MODE_AND4) begin
            raw = comb_val;
        end else begin
            raw = state_d;
        end
        cell_out_d = enable_q & (raw ^ out_inv_q);                // [RULE1] [RULE6]
    end

    // cell state, output and edge interrupt
    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            state_q  <= 1'b0;
            gclk_q   <= 1'b0;
            cell_out <= 1'b0;
            pin_out  <= 1'b0;
            pin_oe_n <= 1'b1;
            cell_irq <= 1'b0;
        end else begin
            state_q  <= state_d;
            gclk_q   <= g_clk;
            cell_out <= cell_out_d;
            // pin only driven while pin enable set, oe is active low
            pin_out  <= pin_oe_q & cell_out_d;                    // [RULE4]
            pin_oe_n <= ~pin_oe_q;                                // [RULE4]
            // one-cycle pulse per qualifying edge
            cell_irq <= (rise_irq_q & cell_out_d & ~cell_out) |   // [RULE2]
                        (fall_irq_q & ~cell_out_d & cell_out);    // [RULE3]
        end
    end

    // readback mux; unmapped indices read zero
    always @* begin
        rd_word = `ZERO_REG;
        if (hit_cl) begin
            rd_word[`BIT_ENABLE]          = enable_q;
            rd_word[`BIT_RISE_IRQ]        = rise_irq_q;
            rd_word[`BIT_FALL_IRQ]        = fall_irq_q;
            rd_word[`BIT_PIN_OE]          = pin_oe_q;
            rd_word[`BIT_STATUS]          = cell_out;             // [RULE5]
            rd_word[`BIT_OUT_INV]         = out_inv_q;
            rd_word[`MODE_HI:`MODE_LO]    = mode_q;
        end else if (hit_ch) begin
            rd_word[`GINV_HI:`GINV_LO]    = gate_inv_q;
        end else if (hit_sel) begin
            rd_word[`S4_HI:`S4_LO]        = in_sel_q[`S4_HI:`S4_LO];
            rd_word[`S3_HI:`S3_LO]        = in_sel_q[`S3_HI:`S3_LO];
            rd_word[`S2_HI:`S2_LO]        = in_sel_q[`S2_HI:`S2_LO];
            rd_word[`S1_HI:`S1_LO]        = in_sel_q[`S1_HI:`S1_LO];
        end else if (hit_gl) begin
            rd_word = gate_lo_q;
        end else if (hit_gh) begin
            rd_word = gate_hi_q;
        end
    end

    // wishbone answer: ack one cycle after request, dropped next cycle
    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= {`ZERO_PAD, `ZERO_REG};
        end else begin
            wb_ack_o <= req;
            if (req) begin
                wb_dat_o <= {`ZERO_PAD, rd_word};
            end
        end
    end

    // register writes, byte lanes honoured; status bit is read only
    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            enable_q   <= 1'b0;
            rise_irq_q <= 1'b0;
            fall_irq_q <= 1'b0;
            pin_oe_q   <= 1'b0;
            out_inv_q  <= 1'b0;
            mode_q     <= `MODE_AND_OR;
            gate_inv_q <= 4'h0;
            in_sel_q   <= `ZERO_REG;
            gate_lo_q  <= `ZERO_REG;
            gate_hi_q  <= `ZERO_REG;
        end else if (wr) begin
            if (hit_cl && wb_sel_i[1]) begin
                enable_q   <= wb_dat_i[`BIT_ENABLE];
                rise_irq_q <= wb_dat_i[`BIT_RISE_IRQ];
                fall_irq_q <= wb_dat_i[`BIT_FALL_IRQ];
            end
            if (hit_cl && wb_sel_i[0]) begin
                pin_oe_q   <= wb_dat_i[`BIT_PIN_OE];
                out_inv_q  <= wb_dat_i[`BIT_OUT_INV];
                mode_q     <= wb_dat_i[`MODE_HI:`MODE_LO];
            end
            if (hit_ch && wb_sel_i[0]) begin
                gate_inv_q <= wb_dat_i[`GINV_HI:`GINV_LO];
            end
            // reserved select bits stay zero
            if (hit_sel && wb_sel_i[1]) begin
                in_sel_q[`S4_HI:`S4_LO] <= wb_dat_i[`S4_HI:`S4_LO];
                in_sel_q[`S3_HI:`S3_LO] <= wb_dat_i[`S3_HI:`S3_LO];
            end
            if (hit_sel && wb_sel_i[0]) begin
                in_sel_q[`S2_HI:`S2_LO] <= wb_dat_i[`S2_HI:`S2_LO];
                in_sel_q[`S1_HI:`S1_LO] <= wb_dat_i[`S1_HI:`S1_LO];
            end
            if (hit_gl && wb_sel_i[1]) begin
                gate_lo_q[15:8] <= wb_dat_i[15:8];
            end
            if (hit_gl && wb_sel_i[0]) begin
                gate_lo_q[7:0]  <= wb_dat_i[7:0];
            end
            if (hit_gh && wb_sel_i[1]) begin
                gate_hi_q[15:8] <= wb_dat_i[15:8];
            end
            if (hit_gh && wb_sel_i[0]) begin
                gate_hi_q[7:0]  <= wb_dat_i[7:0];
            end
        end
    end

endmodule // logic_cell
`default_nettype wire

// ### tb/logic_cell_chk.sv
`timescale 1ns/100ps
`default_nettype none
`include "logic_cell_defs.vh"
// port checks: bus handshake, pin gating, edge interrupt
module logic_cell_chk (
    // clock and reset
    input wire logic              core_clk,
    input wire logic              nrst,
    // bus
    input wire logic              wb_cyc_i,
    input wire logic              wb_stb_i,
    input wire logic              wb_we_i,
    input wire logic [`ADR_W-1:0] wb_adr_i,
    input wire logic [`DAT_W-1:0] wb_dat_o,
    input wire logic              wb_ack_o,
    // cell result and pin
    input wire logic              cell_out,
    input wire logic              pin_out,
    input wire logic              pin_oe_n,
    input wire logic              cell_irq
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!nrst);
    // request, index, answered transfers
    wire              req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire [`IDX_W-1:0] idx = wb_adr_i[12:2];
    wire              rd_ack = wb_ack_o && !wb_we_i;
    wire              wr_ack = wb_ack_o && wb_we_i;
    // one of the five mapped places
    wire              mapped = idx inside {`IDX_CON_LOW, `IDX_CON_HIGH, `IDX_IN_SEL,
                                           `IDX_GATE_LOW, `IDX_GATE_HIGH};

    a_ack_answers: assert property (req |=> wb_ack_o)
        else $error("request not answered");
    a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack too long");
    a_no_stray_ack: assert property (!req |=> !wb_ack_o)
        else $error("stray acknowledge");
    a_unmapped_zero: assert property (rd_ack && !mapped |-> wb_dat_o == 32'h00000000)
        else $error("unmapped read not zero");
    a_status_read: assert property (
        rd_ack && idx == `IDX_CON_LOW |-> wb_dat_o[`BIT_STATUS] == $past(cell_out))
        else $error("status bit wrong");
    a_pin_gated: assert property (pin_out |-> !pin_oe_n)
        else $error("pin data while pin disabled");
    a_pin_tracks: assert property (!pin_oe_n |-> pin_out == cell_out)
        else $error("pin data wrong");
    a_oe_by_write: assert property (
        pin_oe_n != $past(pin_oe_n) |-> wr_ack || $past(wr_ack))
        else $error("pin enable moved");
    a_irq_on_edge: assert property (cell_irq |-> cell_out != $past(cell_out))
        else $error("stray interrupt");
endmodule // logic_cell_chk

bind logic_cell logic_cell_chk logic_cell_chk_i (.*);
`default_nettype wire

// ### tb/source_model.sv
`timescale 1ns/100ps
`default_nettype none
// far-side sources as plain levels
module source_model (
    // bench levels
    input  wire logic [23:0] lv,
    // toward the cell
    output wire logic [23:0] src
);
    // all sources are core-clock synchronous, so no glitch is modelled
    assign src = lv;
endmodule // source_model
`default_nettype wire

// ### tb/testbench.sv
`timescale 1ns/100ps
`default_nettype none
`include "logic_cell_defs.vh"
// logic cell tests
module testbench;
    // clock, reset, bus master
    logic              core_clk = 1'b0;
    logic              nrst = 1'b0;
    logic              cyc = 1'b0;
    logic              stb = 1'b0;
    logic              we = 1'b0;
    logic [`ADR_W-1:0] adr = 13'h0000;
    logic [3:0]        sel = 4'h0;
    logic [`DAT_W-1:0] wdat = 32'h00000000;
    // design outputs
    wire  [`DAT_W-1:0] rdat;
    wire               ack, cell_out, pin_out, pin_oe_n, cell_irq;
    // far-side levels
    logic [23:0]       lv = 24'h000000;
    wire  [23:0]       s;
    // scratch and counters
    logic [31:0]       q;
    logic [3:0]        g;
    logic              f;
    logic [23:0]       hot;
    logic [2:0]        md;
    int                n_fail = 0;
    int                n_tests = 0;
    // register table: index, written, read back (status bit reads low)
    logic [10:0] ri [5] = '{`IDX_CON_LOW, `IDX_CON_HIGH, `IDX_IN_SEL, `IDX_GATE_LOW, `IDX_GATE_HIGH};
    logic [15:0] wv [5] = '{16'h0C67, 16'h000F, 16'h7777, 16'hA5C3, 16'h5A3C};
    logic [15:0] rv [5] = '{16'h0C27, 16'h000F, 16'h7777, 16'hA5C3, 16'h5A3C};
    // source bit per select code; -2 tied low, -1 own feedback
    int smap [4][8] = '{'{0, 1, 2, 3, 4, -2, 5, 6}, '{7, 8, 9, 10, 11, 12, 21, 22},
                        '{13, -1, 14, 15, 16, 17, 22, 23}, '{18, 8, 19, 20, -2, -2, 21, 23}};
    // 8m picks mode m, else {expected, pins d c b a}
    logic [7:0] sq [$] = '{8'h83, 8'h12, 8'h10, 8'h04, 8'h00, 8'h0A,
        8'h84, 8'h04, 8'h02, 8'h13, 8'h11, 8'h10, 8'h01, 8'h18, 8'h0C,
        8'h85, 8'h04, 8'h02, 8'h03, 8'h00, 8'h1B, 8'h18, 8'h0C,
        8'h86, 8'h04, 8'h00, 8'h13, 8'h10, 8'h09, 8'h00, 8'h1B, 8'h10, 8'h0B,
        8'h87, 8'h04, 8'h13, 8'h01, 8'h13, 8'h12, 8'h10, 8'h04, 8'h18};

    // 4 ns period
    always #2 core_clk = ~core_clk;

    source_model source_model_i (.lv(lv), .src(s));
    logic_cell logic_cell_i (
        .core_clk(core_clk), .nrst(nrst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .cell_input_pin_a(s[0]), .peripheral_clock(s[1]), .secondary_oscillator(s[2]),
        .low_power_rc_clock(s[3]), .reference_clock_out(s[4]), .timer2_match(s[5]),
        .timer3_match(s[6]), .cell_input_pin_b(s[7]), .cell1_output(s[8]),
        .comparator1_output(s[9]), .uart2_transmit(s[10]), .adc_done(s[11]),
        .dma0_irq(s[12]), .cell_input_pin_c(s[13]), .comparator2_output(s[14]),
        .serial2_data_out(s[15]), .uart2_receive(s[16]), .dma1_irq(s[17]),
        .cell_input_pin_d(s[18]), .comparator3_output(s[19]), .serial2_data_in(s[20]),
        .compare1_output(s[21]), .compare2_output(s[22]), .compare3_output(s[23]),
        .cell_out(cell_out), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .cell_irq(cell_irq)
    );

    // count and report a mismatch
    task automatic fail(input string m);
        n_fail++;
        $display("unexpected %0t: %s", $time, m);
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
        n_tests++;
        if (got !== exp) fail(m);
    endtask
    // one classic cycle, held until ack is sampled high
    task automatic bus(input logic w, input logic [10:0] i, input logic [3:0] be,
                       input logic [15:0] d);
        @(posedge core_clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {i, 2'b00};
        sel <= be;
        wdat <= {16'h0000, d};
        do @(posedge core_clk); while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic wr(input logic [10:0] i, input logic [15:0] d);
        bus(1'b1, i, 4'h3, d);
    endtask
    task automatic rd(input logic [10:0] i, input logic [15:0] e);
        bus(1'b0, i, 4'hF, 16'h0000);
        chk(q[15:0], e, "read data");
    endtask
    // new levels; the cell samples them at the next edge
    task automatic drive(input logic [23:0] v);
        @(posedge core_clk);
        lv <= v;
        repeat (2) @(posedge core_clk);
    endtask
    // pin a level, output edge and a one-cycle interrupt
    task automatic edge_chk(input logic a, input logic ex);
        drive(pv({3'b000, a}));
        chk(cell_out, a, "output edge");
        chk(cell_irq, ex, "interrupt");
        @(posedge core_clk);
        chk(cell_irq, 1'b0, "interrupt drop");
    endtask
    // pins a..d onto their source bits
    function automatic logic [23:0] pv(input logic [3:0] p);
        return {5'h00, p[3], 4'h0, p[2], 5'h00, p[1], 6'h00, p[0]};
    endfunction
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    // hang guard
    initial begin
        repeat (40000) @(posedge core_clk);
        fail("watchdog");
        print_verdict;
    end

    initial begin
        repeat (10) @(posedge core_clk);
        nrst <= 1'b1;
        // reset values, readback, byte lane, unmapped
        foreach (ri[i]) rd(ri[i], 16'h0000);
        foreach (ri[i]) begin
            wr(ri[i], wv[i]);
            rd(ri[i], rv[i]);
        end
        bus(1'b1, `IDX_GATE_LOW, 4'h2, 16'h0000);
        rd(`IDX_GATE_LOW, 16'h00C3);
        bus(1'b1, 11'h476, 4'hF, 16'hFFFF);
        rd(11'h476, 16'h0000);
        $display("test registers done");
        // each select code via gate 1, except source 3 code 001 (own feedback)
        wr(`IDX_CON_HIGH, 16'h0000);
        wr(`IDX_GATE_HIGH, 16'h0000);
        wr(`IDX_CON_LOW, 16'h8001);
        for (int i = 0; i < 4; i++) begin
            for (int c = 0; c < 8; c++) begin
                if (smap[i][c] == -1) continue;
                hot = (smap[i][c] < 0) ? 24'hFFFFFF : 24'h000001 << smap[i][c];
                f = smap[i][c] >= 0;
                wr(`IDX_IN_SEL, 16'(c << (4 * i)));
                wr(`IDX_GATE_LOW, 16'(2 << (2 * i)));
                drive(hot);
                chk(cell_out, f, "true term");
                drive(~hot);
                chk(cell_out, 1'b0, "true term off");
                wr(`IDX_GATE_LOW, 16'(1 << (2 * i)));
                drive(hot);
                chk(cell_out, !f, "negated term");
            end
        end
        $display("test sources done");
        // gate n follows pin n; modes, inversions
        wr(`IDX_IN_SEL, 16'h0000);
        wr(`IDX_GATE_LOW, 16'h0802);
        wr(`IDX_GATE_HIGH, 16'h8020);
        for (int m = 0; m < 3; m++) begin
            for (int k = 0; k < 4; k++) begin
                wr(`IDX_CON_HIGH, 16'(5 * k));
                wr(`IDX_CON_LOW, 16'(32'h8080 | (k % 2) << 5 | m));
                for (int p = 0; p < 16; p++) begin
                    g = 4'(p ^ 5 * k);
                    f = (m == 0) ? (g[0] & g[1]) | (g[2] & g[3])
                      : (m == 1) ? (g[0] | g[1]) ^ (g[2] | g[3]) : &g;
                    drive(pv(4'(p)));
                    chk(cell_out, f ^ (k % 2 == 1), "mode");
                    chk(pin_out, f ^ (k % 2 == 1), "pin data");
                end
            end
        end
        // disabled stays low even when inverted; pin stays driven until pin enable clears
        wr(`IDX_CON_LOW, 16'h00A0);
        drive(pv(4'hF));
        chk(cell_out, 1'b0, "disabled");
        chk(pin_oe_n, 1'b0, "pin on");
        wr(`IDX_CON_LOW, 16'h0000);
        drive(pv(4'h0));
        chk(pin_oe_n, 1'b1, "pin off");
        $display("test modes done");
        // each edge enable alone
        wr(`IDX_CON_HIGH, 16'h0000);
        wr(`IDX_CON_LOW, 16'h8801);
        edge_chk(1'b1, 1'b1);
        edge_chk(1'b0, 1'b0);
        wr(`IDX_CON_LOW, 16'h8401);
        edge_chk(1'b1, 1'b0);
        edge_chk(1'b0, 1'b1);
        $display("test interrupts done");
        // stored modes, status read each step
        foreach (sq[i]) begin
            if (sq[i][7]) begin
                md = sq[i][2:0];
                wr(`IDX_CON_LOW, {13'h1010, md});
            end else begin
                drive(pv(sq[i][3:0]));
                repeat (2) @(posedge core_clk);
                chk(cell_out, sq[i][4], "state");
                rd(`IDX_CON_LOW, {9'h101, sq[i][4], 3'b000, md});
            end
        end
        $display("test sequential done");
        print_verdict;
    end
endmodule // testbench
`default_nettype wire
